/* logic/ewpt_timer.sv */
/*
  ewpt_timer.sv: sixteen-bit event / window / pulse-width timer, APB slave.
  assumes: pclk 10 MHz, presetn asynchronous active low, timer_input_pin
  and stop_mode_req asynchronous to pclk.
*/
//
// Notes on behaviour
// R01 - event mode counts selected pin edges
// R02 - event match at opposite edge: irq, clear
// R03 - source holds each level two cycles
// R04 - auto-capture copies counter each source tick except in pulse mode
// R05 - software waits one tick before reading
// R06 - read auto-capture only while running
// R07 - window counts pin AND source clock
// R08 - window polarity positive or negative selectable
// R09 - window match raises irq, clears counter
// R10 - window slower than source clock
// R11 - pulse mode starts on trigger edge
// R12 - capture mode one single, zero double
// R13 - single: opposite edge captures, loads one, waits
// R14 - double: capture both edges, clear trigger
// R15 - software reads capture before next trigger
// R16 - single-edge counter holds one after capture
// R17 - software discards first captured value
// R18 - software picks trigger edge for level
// R19 - stop mode forces start control zero
// R20 - sixteen-bit registers, capture byte readable
`timescale 1ns/1ps
`default_nettype none
`include "ewpt_consts.svh"

module ewpt_timer #(
  parameter int CNT_WIDTH = 16
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic [31:0] prdata,
  // pins
  input  wire logic        timer_input_pin,
  input  wire logic        stop_mode_req,
  output var  logic        timer_match_irq
);

  // the register map and byte lanes are laid out for sixteen bits only
  if (CNT_WIDTH != 16) begin : g_width_check
    $error("ewpt_timer supports only a 16-bit counter");
  end

  // ------------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------------
  logic [1:0] pin_sync;
  logic [1:0] stop_sync;
  logic       pin_prev;
  logic       stop_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync  <= 2'h0;
      stop_sync <= 2'h0;
      pin_prev  <= 1'b0;
      stop_prev <= 1'b0;
    end else begin
      pin_sync  <= {pin_sync[0], timer_input_pin};
      stop_sync <= {stop_sync[0], stop_mode_req};
      pin_prev  <= pin_sync[1];
      stop_prev <= stop_sync[1];
    end
  end

  logic pin_lvl;
  logic pin_rise;
  logic pin_fall;
  logic stop_entry;
  assign pin_lvl    = pin_sync[1];
  assign pin_rise   = pin_sync[1] & ~pin_prev;
  assign pin_fall   = ~pin_sync[1] & pin_prev;
  assign stop_entry = stop_sync[1] & ~stop_prev;

  // ------------------------------------------------------------------
  // registers and apb
  // ------------------------------------------------------------------
  ewpt_pkg::ewpt_ctrl_type ctrl;
  logic [15:0]             compare_value_reg;
  logic [15:0]             capture_value_reg;
  logic [15:0]             counter;
  logic                    apb_write;
  logic                    apb_read;
  logic                    addr_ok;

  assign apb_write = psel & penable & pwrite & pready;
  assign apb_read  = psel & ~penable & ~pwrite;

  function automatic logic mapped(input logic [11:0] a);
    return (a == `EWPT_OFF_CTRL) || (a == `EWPT_OFF_COMPARE) ||
           (a == `EWPT_OFF_CAPTURE) || (a == `EWPT_OFF_CAP_LO) ||
           (a == `EWPT_OFF_CAP_HI) || (a == `EWPT_OFF_STATUS) ||
           (a == `EWPT_OFF_POWER);
  endfunction : mapped

  assign addr_ok = mapped(paddr);

  // no wait state: ready and error rise in the access phase's first cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (apb_read) begin
      unique case (paddr)
        `EWPT_OFF_CTRL:    prdata <= {23'h0, ctrl};
        `EWPT_OFF_COMPARE: prdata <= {16'h0, compare_value_reg};
        `EWPT_OFF_CAPTURE: prdata <= {16'h0, capture_value_reg};
        `EWPT_OFF_CAP_LO:  prdata <= {24'h0, capture_value_reg[7:0]};  // see R20
        `EWPT_OFF_CAP_HI:  prdata <= {24'h0, capture_value_reg[15:8]}; // see R20
        `EWPT_OFF_STATUS:  prdata <= {15'h0, pin_lvl, counter};
        default:           prdata <= 32'h0;
      endcase
    end
  end

  logic [1:0] next_start;
  always_comb begin
    next_start = ctrl.start_edge_control;
    if (apb_write && paddr == `EWPT_OFF_CTRL) begin
      next_start = pwdata[`EWPT_CTRL_ST_LSB +: 2];
    end
    if (stop_entry) begin
      next_start = `EWPT_ST_STOP; // see R19
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ewpt_pkg::ewpt_ctrl_type'(`EWPT_CTRL_RESET);
    end else begin
      if (apb_write && paddr == `EWPT_OFF_CTRL) begin
        ctrl <= ewpt_pkg::ewpt_ctrl_type'(pwdata[`EWPT_CTRL_WIDTH-1:0]);
      end
      ctrl.start_edge_control <= next_start;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_value_reg <= `EWPT_CMP_RESET;
    end else if (apb_write && paddr == `EWPT_OFF_COMPARE) begin
      compare_value_reg <= pwdata[15:0];
    end
  end

  // ------------------------------------------------------------------
  // internal source clock: a one-cycle tick from a prescaler
  // ------------------------------------------------------------------
  function automatic logic [15:0] divisor(input logic [1:0] sel);
    unique case (sel)
      2'h0: return `EWPT_DIV0;
      2'h1: return `EWPT_DIV1;
      2'h2: return `EWPT_DIV2;
      2'h3: return `EWPT_DIV3;
    endcase
  endfunction : divisor

  logic [15:0] presc;
  logic        src_tick;
  logic        running;
  assign running  = ctrl.start_edge_control != `EWPT_ST_STOP;
  assign src_tick = running && (presc >= divisor(ctrl.source_clock_select) - 16'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= 16'h0;
    end else if (!running || src_tick) begin
      presc <= 16'h0;
    end else begin
      presc <= presc + 16'h1;
    end
  end

  // ------------------------------------------------------------------
  // edge selection
  // ------------------------------------------------------------------
  logic trig_edge;
  logic opp_edge;
  logic win_open;
  assign trig_edge = (ctrl.start_edge_control == `EWPT_ST_FALL) ? pin_fall : pin_rise;
  assign opp_edge  = (ctrl.start_edge_control == `EWPT_ST_FALL) ? pin_rise : pin_fall;
  assign win_open  = pin_lvl ^ ctrl.window_negative; // see R08

  // ------------------------------------------------------------------
  // counter engine
  // ------------------------------------------------------------------
  logic        armed;   // pulse mode: counting from trigger to opposite edge (single) or to stop (double)
  logic [15:0] next_counter;
  logic        next_armed;
  logic        next_irq;
  logic        cap_pulse;

  always_comb begin
    next_counter = counter;
    next_armed   = armed;
    next_irq     = 1'b0;
    cap_pulse    = 1'b0;
    if (!running) begin
      next_counter = 16'h0;
      next_armed   = 1'b0;
    end else begin
      unique case (ctrl.mode)
        ewpt_pkg::EWPT_MODE_EVENT: begin
          if (trig_edge) begin
            next_counter = counter + 16'h1; // see R01
          end
          if (opp_edge && counter == compare_value_reg) begin
            next_irq     = 1'b1; // see R02
            next_counter = 16'h0;
          end
        end
        ewpt_pkg::EWPT_MODE_WINDOW: begin
          if (src_tick && win_open) begin
            if (counter + 16'h1 == compare_value_reg) begin
              next_irq     = 1'b1; // see R09
              next_counter = 16'h0;
            end else begin
              next_counter = counter + 16'h1; // see R07
            end
          end
        end
        ewpt_pkg::EWPT_MODE_PULSE: begin
          if (armed && src_tick) begin
            next_counter = counter + 16'h1;
          end
          if (trig_edge) begin
            next_armed = 1'b1; // see R11
            if (!ctrl.capture_edge_mode && armed) begin
              cap_pulse    = 1'b1; // see R14
              next_irq     = 1'b1;
              next_counter = 16'h0;
            end
          end else if (opp_edge && armed) begin
            cap_pulse = 1'b1; // see R12
            next_irq  = 1'b1;
            if (ctrl.capture_edge_mode) begin
              next_armed   = 1'b0; // see R13
              next_counter = `EWPT_CNT_ONE; // see R16
            end
          end
        end
        default: begin
          next_counter = counter;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter         <= 16'h0;
      armed           <= 1'b0;
      timer_match_irq <= 1'b0;
    end else begin
      counter         <= next_counter;
      armed           <= next_armed;
      timer_match_irq <= next_irq;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_value_reg <= 16'h0;
    end else if (cap_pulse) begin
      capture_value_reg <= counter;
    end else if (running && ctrl.auto_capture_enable && src_tick &&
                 ctrl.mode != ewpt_pkg::EWPT_MODE_PULSE) begin
      capture_value_reg <= counter; // see R04
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  sequence s_single_cap;
    running && ctrl.mode == ewpt_pkg::EWPT_MODE_PULSE && ctrl.capture_edge_mode
      && armed && opp_edge && !trig_edge;
  endsequence

  a_stop_clears_start: assert property (@(posedge pclk) disable iff (!presetn) // see R19
    stop_entry |=> ctrl.start_edge_control == `EWPT_ST_STOP)
    else $error("stop entry did not clear start control");

  a_event_counts_edge: assert property (@(posedge pclk) disable iff (!presetn) // see R01
    running && ctrl.mode == ewpt_pkg::EWPT_MODE_EVENT && trig_edge && !opp_edge
      && !(apb_write && paddr == `EWPT_OFF_CTRL) && !stop_entry
    |=> counter == $past(counter) + 16'h1)
    else $error("event edge not counted");

  a_event_match_irq: assert property (@(posedge pclk) disable iff (!presetn) // see R02
    running && ctrl.mode == ewpt_pkg::EWPT_MODE_EVENT && opp_edge
      && counter == compare_value_reg
    |=> timer_match_irq && counter == 16'h0)
    else $error("event match did not interrupt and clear");

  a_window_match_irq: assert property (@(posedge pclk) disable iff (!presetn) // see R09
    running && ctrl.mode == ewpt_pkg::EWPT_MODE_WINDOW && src_tick && win_open
      && counter + 16'h1 == compare_value_reg
    |=> timer_match_irq && counter == 16'h0)
    else $error("window match did not interrupt and clear");

  a_window_closed_hold: assert property (@(posedge pclk) disable iff (!presetn) // see R07
    running && ctrl.mode == ewpt_pkg::EWPT_MODE_WINDOW && !win_open
      && !(apb_write && paddr == `EWPT_OFF_CTRL) && !stop_entry
    |=> counter == $past(counter))
    else $error("window counted while closed");

  a_single_cap_hold: assert property (@(posedge pclk) disable iff (!presetn) // see R16
    s_single_cap |=> counter == `EWPT_CNT_ONE && !armed && timer_match_irq
      && capture_value_reg == $past(counter))
    else $error("single-edge capture wrong");

  a_double_trig_cap: assert property (@(posedge pclk) disable iff (!presetn) // see R14
    running && ctrl.mode == ewpt_pkg::EWPT_MODE_PULSE && !ctrl.capture_edge_mode
      && armed && trig_edge
    |=> timer_match_irq && counter == 16'h0 && armed)
    else $error("double-edge trigger capture wrong");

  a_auto_capture: assert property (@(posedge pclk) disable iff (!presetn) // see R04
    running && ctrl.auto_capture_enable && src_tick
      && ctrl.mode == ewpt_pkg::EWPT_MODE_EVENT
    |=> capture_value_reg == $past(counter))
    else $error("auto-capture missed");

  a_apb_ready_one: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready)
    else $error("apb ready timing wrong");

endmodule : ewpt_timer
`default_nettype wire

/* logic/ewpt_consts.svh */
/*
  ewpt_consts.svh: register offsets, field positions, reset values and timing
  constants of the event/window/pulse-width timer.
  assumes: included by its bare name from the package and the design file.
*/
`ifndef EWPT_CONSTS_SVH
`define EWPT_CONSTS_SVH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define EWPT_OFF_CTRL      12'h000
`define EWPT_OFF_COMPARE   12'h004
`define EWPT_OFF_CAPTURE   12'h008
`define EWPT_OFF_CAP_LO    12'h00c
`define EWPT_OFF_CAP_HI    12'h010
`define EWPT_OFF_STATUS    12'h014
`define EWPT_OFF_POWER     12'h018

// ------------------------------------------------------------------
// control register fields
// ------------------------------------------------------------------
`define EWPT_CTRL_CK_LSB   0
`define EWPT_CTRL_MODE_LSB 2
`define EWPT_CTRL_ST_LSB   4
`define EWPT_CTRL_ACAP_BIT 6
`define EWPT_CTRL_MCAP_BIT 7
`define EWPT_CTRL_WNEG_BIT 8
`define EWPT_CTRL_WIDTH    9
`define EWPT_CTRL_RESET    9'h000
`define EWPT_CMP_RESET     16'hffff

// ------------------------------------------------------------------
// start-edge control codes and source-clock dividers
// ------------------------------------------------------------------
`define EWPT_ST_STOP       2'h0
`define EWPT_ST_RISE       2'h2
`define EWPT_ST_FALL       2'h3
`define EWPT_DIV0          16'h0800
`define EWPT_DIV1          16'h0080
`define EWPT_DIV2          16'h0008
`define EWPT_DIV3          16'h0001
`define EWPT_CNT_ONE       16'h0001

`endif

/* logic/ewpt_pkg.sv */
/*
  ewpt_pkg.sv: types of the event/window/pulse-width timer.
  assumes: ewpt_consts.svh is on the include path.
*/
`include "ewpt_consts.svh"

package ewpt_pkg;

  typedef enum logic [1:0] {
    EWPT_MODE_EVENT,
    EWPT_MODE_WINDOW,
    EWPT_MODE_PULSE,
    EWPT_MODE_IDLE
  } ewpt_mode_type;

  typedef struct packed {
    logic          window_negative;
    logic          capture_edge_mode;
    logic          auto_capture_enable;
    logic [1:0]    start_edge_control;
    ewpt_mode_type mode;
    logic [1:0]    source_clock_select;
  } ewpt_ctrl_type;

endpackage : ewpt_pkg

/* verification/ewpt_pulse_src.sv */
/*
  ewpt_pulse_src.sv: model of the outside pulse source on the timer pin.
  assumes: one caller of hold at a time, called just after a pclk edge.
*/
`timescale 1ns/1ps
`default_nettype none

module ewpt_pulse_src (
  // clock
  input  wire logic pclk,
  // pin
  output var  logic pin
);
  initial pin = 1'b0;

  // ----------------------------------------------------------------
  // level driver
  // ----------------------------------------------------------------
  // every level stands at least four cycles, twice the minimum, so a slow
  // window never outruns the source clock
  task automatic hold(input logic lvl, input int n);
    @(posedge pclk);
    pin <= lvl;
    repeat ((n < 4) ? 4 : n) @(posedge pclk);
  endtask : hold
endmodule : ewpt_pulse_src

`default_nettype wire

/* verification/tb.sv */
/*
  tb.sv: self-checking bench of the event/window/pulse-width timer.
  assumes: ewpt_pkg, ewpt_timer and ewpt_pulse_src compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ewpt_consts.svh"

module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        pin;
  logic        stop_mode_req = 1'b0;
  logic        timer_match_irq;
  logic        pin_q = 1'b0;
  logic [31:0] v, a, b;
  logic [31:0] caps [4];
  logic        e;
  int          hs [4];
  int          err_total = 0, tests_run = 0, irq_cnt = 0, cyc = 0, t_edge = 0;
  int          seed = 5194, i, k, i0, t_op;

  always #50 pclk = ~pclk;

  ewpt_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .timer_input_pin(pin),
    .stop_mode_req(stop_mode_req), .timer_match_irq(timer_match_irq));
  ewpt_pulse_src src (.pclk(pclk), .pin(pin));

  // ----------------------------------------------------------------
  // monitors
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    pin_q <= pin;
    if (pin !== pin_q) t_edge <= cyc;
    if (timer_match_irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
                     output logic [31:0] q, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    er = pslverr;
    if (n >= 20) err_total++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    logic [31:0] q;
    logic        er;
    apb(1'b1, ad, d, q, er);
  endtask : wr

  task automatic rd(input logic [11:0] ad, output logic [31:0] q);
    logic er;
    apb(1'b0, ad, 32'h0, q, er);
  endtask : rd

  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    irq_cnt = 0;
  endtask : do_reset

  function automatic logic [31:0] cw(logic [1:0] sel, ewpt_pkg::ewpt_mode_type m,
                                     logic [1:0] st, logic ac, logic mc, logic wn);
    ewpt_pkg::ewpt_ctrl_type t;
    t = '{wn, mc, ac, st, m, sel};
    return {23'h0, t};
  endfunction : cw

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    rd(`EWPT_OFF_CTRL, v);
    chk("ctrl_reset", 32'h0, v);
    rd(`EWPT_OFF_COMPARE, v);
    chk("compare_reset", 32'h0000ffff, v);
    apb(1'b0, 12'h020, 32'h0, v, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    // both counting edges, the pin idling at the opposite level
    for (i = 0; i < 2; i++) begin
      do_reset();
      src.hold(i[0], 6);
      wr(`EWPT_OFF_COMPARE, 32'h3);
      wr(`EWPT_OFF_CTRL, cw(2'h3, ewpt_pkg::EWPT_MODE_EVENT,
                            i ? `EWPT_ST_FALL : `EWPT_ST_RISE, 1'b0, 1'b0, 1'b0));
      for (k = 0; k < 3; k++) begin
        if (k == 2) begin
          rd(`EWPT_OFF_STATUS, v);
          chk("event_count", 32'h2, {16'h0, v[15:0]});
          chk("event_no_irq", 32'h0, irq_cnt);
        end
        src.hold(!i[0], 6);
        src.hold(i[0], 6);
      end
      chk("event_irq", 32'h1, irq_cnt);
      rd(`EWPT_OFF_STATUS, v);
      chk("event_clear", 32'h0, {16'h0, v[15:0]});
    end
    // positive and negative window, thirteen ticks against compare five
    for (i = 0; i < 2; i++) begin
      do_reset();
      src.hold(i[0], 6);
      wr(`EWPT_OFF_COMPARE, 32'h5);
      wr(`EWPT_OFF_CTRL, cw(2'h3, ewpt_pkg::EWPT_MODE_WINDOW, `EWPT_ST_RISE,
                            1'b0, 1'b0, i[0]));
      src.hold(i[0], 8);
      chk("window_shut", 32'h0, irq_cnt);
      src.hold(!i[0], 12);
      src.hold(i[0], 8);
      chk("window_irq", 32'h2, irq_cnt);
      rd(`EWPT_OFF_STATUS, v);
      chk("window_wrap", 32'h3, {16'h0, v[15:0]});
    end
    // single-edge capture of high widths
    do_reset();
    src.hold(1'b0, 6);
    wr(`EWPT_OFF_CTRL, cw(2'h3, ewpt_pkg::EWPT_MODE_PULSE, `EWPT_ST_RISE,
                          1'b0, 1'b1, 1'b0));
    for (k = 0; k < 4; k++) begin
      hs[k] = (k < 2) ? 8 : 6 + $unsigned($random(seed)) % 15;
      src.hold(1'b1, hs[k]);
      src.hold(1'b0, 6);
      rd(`EWPT_OFF_CAPTURE, caps[k]);
      rd(`EWPT_OFF_CAP_LO, v);
      chk("cap_low", {24'h0, caps[k][7:0]}, v);
      rd(`EWPT_OFF_CAP_HI, v);
      chk("cap_high", {24'h0, caps[k][15:8]}, v);
    end
    chk("single_irq", 32'h4, irq_cnt);
    chk("single_hold_one", caps[0] + 32'h1, caps[1]);
    for (k = 2; k < 4; k++) begin
      chk("single_delta", hs[k] - hs[1], caps[k] - caps[1]);
    end
    // double-edge capture of a low-starting period
    do_reset();
    src.hold(1'b1, 6);
    wr(`EWPT_OFF_CTRL, cw(2'h3, ewpt_pkg::EWPT_MODE_PULSE, `EWPT_ST_FALL,
                          1'b0, 1'b0, 1'b0));
    for (k = 0; k < 3; k++) begin
      src.hold(1'b0, 6 + $unsigned($random(seed)) % 10);
      i0 = irq_cnt;
      src.hold(1'b1, 6);
      chk("double_mid_irq", i0 + 1, irq_cnt);
      t_op = t_edge;
      rd(`EWPT_OFF_CAPTURE, a);
      src.hold(1'b1, 4 + $unsigned($random(seed)) % 10);
      src.hold(1'b0, 6);
      rd(`EWPT_OFF_CAPTURE, b);
      chk("double_span", t_edge - t_op, b - a);
    end
    // auto-capture, then stop-mode entry
    do_reset();
    src.hold(1'b0, 6);
    wr(`EWPT_OFF_CTRL, cw(2'h3, ewpt_pkg::EWPT_MODE_EVENT, `EWPT_ST_RISE,
                          1'b1, 1'b0, 1'b0));
    for (k = 0; k < 2; k++) begin
      src.hold(1'b1, 6);
      src.hold(1'b0, 6);
    end
    rd(`EWPT_OFF_CAPTURE, v);
    chk("auto_capture", 32'h2, {16'h0, v[15:0]});
    stop_mode_req <= 1'b1;
    src.hold(1'b0, 6);
    rd(`EWPT_OFF_CTRL, v);
    chk("stop_ctrl", cw(2'h3, ewpt_pkg::EWPT_MODE_EVENT, `EWPT_ST_STOP,
                        1'b1, 1'b0, 1'b0), v);
    src.hold(1'b1, 6);
    src.hold(1'b0, 6);
    rd(`EWPT_OFF_STATUS, v);
    chk("stop_cleared", 32'h0, {16'h0, v[15:0]});
    stop_mode_req <= 1'b0;
    close_out();
  end

  // a hung handshake or pin sequence still ends the run with a verdict
  initial begin
    repeat (30000) @(posedge pclk);
    err_total++;
    close_out();
  end
endmodule : tb

`default_nettype wire
